// ===== core/wdog_defs.svh
// Constants for the halt-then-reset watchdog block.
// Summary of operation
// R1 - Writing timeout value arms the watchdog countdown (the code starts it only while the CTRL arm bit is already set)
// R2 - Expiry raises halt interrupt before any reset
// R3 - Reset follows 300 ms later unless inhibited
// R4 - Expiry records watchdog cause in reset reason
// R5 - Indicator LED off while armed, on after expiry
// R6 - Software later disarms and clears diagnostic inhibit
// R7 - Reset enable bit zero blocks hardware reset
// R8 - Reset leaves watchdog disarmed, inhibit and halt clear
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WD_OFS_CTRL     8'h00
`define WD_OFS_TIMEOUT  8'h04
`define WD_OFS_COUNT    8'h08
`define WD_OFS_REASON   8'h0c
`define WD_OFS_STATUS   8'h10
`define WD_OFS_MASK     8'h14
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WD_CTRL_ARM     0
`define WD_CTRL_INHIBIT 1
`define WD_CTRL_RSTEN   2
`define WD_CTRL_SVC     3
`define WD_REASON_WDOG  0
`define WD_ST_EXPIRE    0
`define WD_ST_RESET     1
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define WD_CTRL_RESET   4'h4
`define WD_CLK_HZ       50000000
`define WD_RESET_DELAY_MS 300
`define WD_RESET_CYCLES (`WD_CLK_HZ / 1000 * `WD_RESET_DELAY_MS)
`define WD_PULSE_CYCLES 16
`define WD_RESP_OKAY    2'h0
`define WD_RESP_SLVERR  2'h2
`endif

// ===== core/wdog_pkg.sv
// Types shared by the watchdog block.
package wdog_pkg;
  typedef enum logic [1:0] {
    WD_IDLE   = 2'b00,
    WD_ARMED  = 2'b01,
    WD_HALTED = 2'b11,
    WD_DONE   = 2'b10
  } wd_state_t;
  typedef logic [31:0] word_t;
endpackage

// ===== core/wdog_ctl_if.sv
// Control and status bundle between register file and timer core.
`timescale 1ns/10ps
interface wdog_ctl_if;
  logic  load;
  logic  service;
  logic  arm;
  logic  inhibit;
  logic  rst_en;
  logic [31:0] timeout;
  logic  expire_pulse;
  logic  reset_pulse;
  logic  expired;
  logic  sys_reset;
  logic [31:0] count;
  modport regs (output load, service, arm, inhibit, rst_en, timeout,
                input expire_pulse, reset_pulse, expired, sys_reset, count);
  modport core (input load, service, arm, inhibit, rst_en, timeout,
                output expire_pulse, reset_pulse, expired, sys_reset, count);
endinterface

// ===== core/wdog_timer.sv
// Watchdog countdown, halt stage and delayed system reset.
`timescale 1ns/10ps
`include "wdog_defs.svh"
module wdog_timer #(
  parameter int unsigned RESET_CYCLES = `WD_RESET_CYCLES,
  parameter int unsigned PULSE_CYCLES = `WD_PULSE_CYCLES
) (
  input  wire logic aclk,    // System clock.
  input  wire logic aresetn, // Synchronous reset, active low.
  wdog_ctl_if.core  ctl      // Control and status bundle.
);
  import wdog_pkg::*;

  initial begin
    if (RESET_CYCLES < 1 || PULSE_CYCLES < 1) begin
      $error("wdog_timer: cycle counts must be at least one");
    end
  end

  wd_state_t   state_ff;
  logic [31:0] count_ff;
  logic [31:0] delay_ff;
  logic [31:0] pulse_ff;
  logic        fire_reset;

  assign ctl.count     = count_ff;
  assign ctl.expired   = (state_ff == WD_HALTED) || (state_ff == WD_DONE);
  assign ctl.sys_reset = (pulse_ff != 32'h0);
  assign ctl.expire_pulse = (state_ff == WD_ARMED) && (count_ff <= 32'h1)
                            && !ctl.load && !ctl.service;
  assign fire_reset = (state_ff == WD_HALTED) && (delay_ff <= 32'h1);
  assign ctl.reset_pulse = fire_reset && ctl.rst_en && !ctl.inhibit; // [R3] [R7]

  // --------------------------------------------------------------------------
  // State and countdown
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= WD_IDLE; // [R8]
      count_ff <= 32'h0;
      delay_ff <= 32'h0;
    end else if (!ctl.arm) begin
      state_ff <= WD_IDLE;
      count_ff <= 32'h0;
    end else if (ctl.load && state_ff != WD_HALTED && state_ff != WD_DONE) begin
      state_ff <= WD_ARMED; // [R1]
      count_ff <= (ctl.timeout == 32'h0) ? 32'h1 : ctl.timeout;
    end else begin
      unique case (state_ff)
        WD_IDLE: begin
          state_ff <= WD_IDLE;
        end
        WD_ARMED: begin
          if (ctl.service) begin
            count_ff <= (ctl.timeout == 32'h0) ? 32'h1 : ctl.timeout;
          end else if (ctl.expire_pulse) begin
            state_ff <= WD_HALTED; // [R2]
            count_ff <= 32'h0;
            delay_ff <= RESET_CYCLES;
          end else begin
            count_ff <= count_ff - 32'h1;
          end
        end
        WD_HALTED: begin
          if (fire_reset) begin
            state_ff <= WD_DONE;
          end else begin
            delay_ff <= delay_ff - 32'h1;
          end
        end
        WD_DONE: begin
          state_ff <= WD_DONE;
        end
      endcase
    end
  end

  // The reset pulse is stretched so that downstream reset logic sees it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_ff <= 32'h0;
    end else if (ctl.reset_pulse) begin
      pulse_ff <= PULSE_CYCLES;
    end else if (pulse_ff != 32'h0) begin
      pulse_ff <= pulse_ff - 32'h1;
    end
  end
endmodule

// ===== core/wdog_regs.sv
// AXI4-Lite register file for the watchdog block.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "wdog_defs.svh"
module wdog_regs (
  input  wire logic        aclk,          // System clock.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  output logic             irq,           // Interrupt, active high.
  wdog_ctl_if.regs         ctl            // Control and status bundle.
);
  import wdog_pkg::*;

  logic [7:0]  awaddr_ff;
  logic        aw_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_have_ff;
  logic [3:0]  ctrl_ff;
  word_t       timeout_ff;
  logic        reason_ff;
  logic [1:0]  status_ff;
  logic [1:0]  mask_ff;
  logic        load_ff;
  logic        svc_ff;
  logic        irq_ff;
  logic        do_write;
  logic [31:0] wmask;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign wmask    = strb_mask(wstrb_ff);
  assign ctl.arm     = ctrl_ff[`WD_CTRL_ARM];
  assign ctl.inhibit = ctrl_ff[`WD_CTRL_INHIBIT];
  assign ctl.rst_en  = ctrl_ff[`WD_CTRL_RSTEN];
  assign ctl.timeout = timeout_ff;
  assign ctl.load    = load_ff;
  assign ctl.service = svc_ff;
  assign irq = irq_ff;

  // --------------------------------------------------------------------------
  // Write channels, taken in either order
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff    <= 1'b0;
      awaddr_ff     <= 8'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff    <= 1'b0;
      wdata_ff     <= 32'h0;
      wstrb_ff     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WD_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit(awaddr_ff, `WD_OFS_CTRL) || hit(awaddr_ff, `WD_OFS_TIMEOUT)
                    || hit(awaddr_ff, `WD_OFS_STATUS) || hit(awaddr_ff, `WD_OFS_MASK)
                    || hit(awaddr_ff, `WD_OFS_REASON) || hit(awaddr_ff, `WD_OFS_COUNT))
                    ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff    <= `WD_CTRL_RESET; // [R8]
      timeout_ff <= 32'h0;
      mask_ff    <= 2'h0;
      load_ff    <= 1'b0;
      svc_ff     <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      svc_ff  <= 1'b0;
      if (do_write && hit(awaddr_ff, `WD_OFS_CTRL) && wstrb_ff[0]) begin
        ctrl_ff <= {1'b0, wdata_ff[2:0]}; // [R7]
        svc_ff  <= wdata_ff[`WD_CTRL_SVC];
      end
      if (do_write && hit(awaddr_ff, `WD_OFS_TIMEOUT)) begin
        timeout_ff <= (timeout_ff & ~wmask) | (wdata_ff & wmask);
        load_ff    <= 1'b1; // [R1]
      end
      if (do_write && hit(awaddr_ff, `WD_OFS_MASK) && wstrb_ff[0]) begin
        mask_ff <= wdata_ff[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sticky flags: a new event wins over a clearing write
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 2'h0;
      reason_ff <= 1'b0;
    end else begin
      if (do_write && hit(awaddr_ff, `WD_OFS_STATUS) && wstrb_ff[0]) begin
        status_ff <= (status_ff & ~wdata_ff[1:0])
                   | {ctl.reset_pulse, ctl.expire_pulse}; // [R2]
      end else begin
        status_ff <= status_ff | {ctl.reset_pulse, ctl.expire_pulse};
      end
      if (ctl.expire_pulse) begin
        reason_ff <= 1'b1; // [R4]
      end else if (do_write && hit(awaddr_ff, `WD_OFS_REASON) && wstrb_ff[0]
                   && wdata_ff[`WD_REASON_WDOG]) begin
        reason_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0; // [R8]
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `WD_RESP_OKAY;
        if (hit(s_axi_araddr, `WD_OFS_CTRL)) begin
          s_axi_rdata <= {27'h0, ctl.expired, ctrl_ff};
        end else if (hit(s_axi_araddr, `WD_OFS_TIMEOUT)) begin
          s_axi_rdata <= timeout_ff;
        end else if (hit(s_axi_araddr, `WD_OFS_COUNT)) begin
          s_axi_rdata <= ctl.count;
        end else if (hit(s_axi_araddr, `WD_OFS_REASON)) begin
          s_axi_rdata <= {31'h0, reason_ff};
        end else if (hit(s_axi_araddr, `WD_OFS_STATUS)) begin
          s_axi_rdata <= {30'h0, status_ff};
        end else if (hit(s_axi_araddr, `WD_OFS_MASK)) begin
          s_axi_rdata <= {30'h0, mask_ff};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `WD_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== core/wdog_top.sv
// Top of the halt-then-reset watchdog with its register file.
`timescale 1ns/10ps
`include "wdog_defs.svh"
module wdog_top #(
  parameter int unsigned RESET_CYCLES = `WD_RESET_CYCLES
) (
  input  wire logic        aclk,          // System clock, 50 MHz.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  output logic             irq,           // Interrupt level, active high.
  output logic             halt_irq,      // Halt interrupt to processor.
  output logic             sys_reset,     // System reset request, active high.
  output logic             wdog_led       // Watchdog indicator, on when lit.
);
  import wdog_pkg::*;

  wdog_ctl_if ctl ();
  logic halt_ff;
  logic led_ff;
  logic sysrst_ff;

  wdog_regs u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .irq           (irq),
    .ctl           (ctl)
  );

  wdog_timer #(
    .RESET_CYCLES (RESET_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl)
  );

  // --------------------------------------------------------------------------
  // Registered pin outputs
  // --------------------------------------------------------------------------
  // Halt stays up until software disarms, so the processor cannot miss it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_ff   <= 1'b0; // [R8]
      led_ff    <= 1'b0;
      sysrst_ff <= 1'b0;
    end else begin
      halt_ff   <= ctl.expired; // [R2]
      led_ff    <= ctl.expired; // [R5]
      sysrst_ff <= ctl.sys_reset; // [R3]
    end
  end

  assign halt_irq  = halt_ff;
  assign wdog_led  = led_ff;
  assign sys_reset = sysrst_ff;
endmodule

// ===== test/wdog_top_properties.sv
// Concurrent checks on the ports of the watchdog top.
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module wdog_top_properties #(
  parameter int unsigned RESET_CYCLES = 50
) (
  input wire logic        aclk,         // Clock.
  input wire logic        aresetn,      // Reset, active low.
  input wire logic [1:0]  s_axi_bresp,  // Write response.
  input wire logic        s_axi_bvalid, // Write response valid.
  input wire logic        s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_rdata,  // Read data.
  input wire logic [1:0]  s_axi_rresp,  // Read response.
  input wire logic        s_axi_rvalid, // Read data valid.
  input wire logic        s_axi_rready, // Read data ready.
  input wire logic        irq,          // Interrupt level.
  input wire logic        halt_irq,     // Halt interrupt.
  input wire logic        sys_reset,    // System reset request.
  input wire logic        wdog_led      // Indicator.
);
  logic [31:0] halt_age_ff;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The reset delay is far beyond a repetition count, so halt time is counted here.
  always_ff @(posedge aclk) begin
    if (!aresetn || !halt_irq) begin
      halt_age_ff <= '0;
    end else begin
      halt_age_ff <= halt_age_ff + 32'h1;
    end
  end

  sequence expire_s;
    $rose(halt_irq);
  endsequence
  sequence rst_pulse_s;
    sys_reset [*8] ##1 sys_reset [*8] ##1 !sys_reset;
  endsequence

  led_tracks_a: assert property (wdog_led == halt_irq)
    else $error("Indicator differs from halt level.");
  halt_first_a: assert property (expire_s |-> !sys_reset)
    else $error("Reset seen before halt.");
  reset_after_halt_a: assert property ($rose(sys_reset) |-> halt_irq)
    else $error("Reset without halt.");
  pulse_len_a: assert property ($rose(sys_reset) |-> rst_pulse_s)
    else $error("Reset pulse length wrong.");
  reset_delay_a: assert property ($rose(sys_reset) |->
    halt_age_ff >= RESET_CYCLES - 1 && halt_age_ff <= RESET_CYCLES + 4)
    else $error("Reset delay after halt wrong.");
  reset_clean_a: assert property ($rose(aresetn) |->
    !halt_irq && !sys_reset && !irq && !wdog_led)
    else $error("Outputs active after reset.");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped early.");
endmodule

bind wdog_top wdog_top_properties #(.RESET_CYCLES(RESET_CYCLES)) wdog_top_props_i (.*);

// ===== test/wdog_cpu_model.sv
// Processor side of the watchdog: an AXI4-Lite master with slow readies.
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Bus master
// ----------------------------------------------------------------------------
module wdog_cpu_model (
  input  wire logic        aclk,          // Clock.
  output logic [7:0]       s_axi_awaddr,  // Write address.
  output logic             s_axi_awvalid, // Write address valid.
  input  wire logic        s_axi_awready, // Write address ready.
  output wdog_pkg::word_t  s_axi_wdata,   // Write data.
  output logic [3:0]       s_axi_wstrb,   // Byte strobes.
  output logic             s_axi_wvalid,  // Write data valid.
  input  wire logic        s_axi_wready,  // Write data ready.
  input  wire logic [1:0]  s_axi_bresp,   // Write response.
  input  wire logic        s_axi_bvalid,  // Write response valid.
  output logic             s_axi_bready,  // Write response ready.
  output logic [7:0]       s_axi_araddr,  // Read address.
  output logic             s_axi_arvalid, // Read address valid.
  input  wire logic        s_axi_arready, // Read address ready.
  input  wire wdog_pkg::word_t s_axi_rdata, // Read data.
  input  wire logic [1:0]  s_axi_rresp,   // Read response.
  input  wire logic        s_axi_rvalid,  // Read data valid.
  output logic             s_axi_rready   // Read data ready.
);
  import wdog_pkg::*;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // Readies come late on purpose, so the slave must hold its answer.
  // Released lines show inverted values, so stale data cannot pass as fresh.
  task automatic wr(input logic [7:0] a, input word_t d, output logic [1:0] r, output bit to);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    to = 1'b1;
    for (n = 0; n < 64 && to; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        to = 1'b0;
        s_axi_bready <= 1'b0;
      end else if (n == 3) begin
        s_axi_bready <= 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output word_t d, output logic [1:0] r, output bit to);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    to = 1'b1;
    for (n = 0; n < 64 && to; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        to = 1'b0;
        s_axi_rready <= 1'b0;
      end else if (n == 2) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask
endmodule

// ===== test/wdog_top_tb.sv
// Self-checking bench for the halt-then-reset watchdog.
`timescale 1ns/10ps
`include "wdog_defs.svh"
`define CHK_EQ(g, e) check_eq(32'(g), 32'(e))
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module wdog_top_tb;
  import wdog_pkg::*;
  localparam int RC = 50;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  word_t       s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        irq, halt_irq, sys_reset, wdog_led;
  int          fails = 0;
  int          n_checks = 0;
  int          m_ctrl = 4;
  int          m_mask = 0;
  logic [15:0] lfsr_q = 16'h0035;

  always #10 aclk = ~aclk;

  wdog_top #(.RESET_CYCLES(RC)) wdog_top_i (.*);
  wdog_cpu_model cpu_i (.*);

  function automatic logic [15:0] lfsr_next();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic bail();
    fails++;
    summarize();
  endtask

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input word_t d);
    logic [1:0] r;
    bit         to;
    cpu_i.wr(a, d, r, to);
    if (to) bail();
    `CHK_EQ(r, (a <= 8'h14) ? `WD_RESP_OKAY : `WD_RESP_SLVERR);
    if (a == `WD_OFS_CTRL) m_ctrl = d[2:0];
    if (a == `WD_OFS_MASK) m_mask = d[1:0];
  endtask

  task automatic rd(input logic [7:0] a, output word_t d);
    logic [1:0] r;
    bit         to;
    cpu_i.rd(a, d, r, to);
    if (to) bail();
    `CHK_EQ(r, (a <= 8'h14) ? `WD_RESP_OKAY : `WD_RESP_SLVERR);
  endtask

  // One armed expiry with the given control bits and interrupt mask.
  task automatic expire_case(input logic [3:0] ctl, input logic [1:0] msk);
    word_t d;
    int    t;
    int    n;
    int    k;
    bit    rexp;
    t = 8 + lfsr_next() % 24;
    rexp = ctl[`WD_CTRL_RSTEN] && !ctl[`WD_CTRL_INHIBIT];
    wr(`WD_OFS_CTRL, 32'(ctl));
    wr(`WD_OFS_MASK, 32'(msk));
    wr(`WD_OFS_TIMEOUT, t);
    `CHK_EQ(wdog_led, 1'b0);
    for (n = 0; n < 200 && halt_irq !== 1'b1; n++) @(posedge aclk);
    if (n == 200) bail();
    `CHK_EQ(n >= t - 7 && n <= t + 1, 1'b1);
    `CHK_EQ(sys_reset, 1'b0);
    `CHK_EQ(wdog_led, 1'b1);
    for (k = 0; k < RC + 20 && sys_reset !== 1'b1; k++) @(posedge aclk);
    `CHK_EQ(k < RC + 20, rexp);
    if (rexp) `CHK_EQ(k >= RC - 2 && k <= RC + 3, 1'b1);
    for (n = 0; n < 40 && sys_reset === 1'b1; n++) @(posedge aclk);
    `CHK_EQ(n, rexp ? `WD_PULSE_CYCLES : 0);
    `CHK_EQ(halt_irq, 1'b1);
    rd(`WD_OFS_REASON, d);
    `CHK_EQ(d[`WD_REASON_WDOG], 1'b1);
    rd(`WD_OFS_CTRL, d);
    `CHK_EQ(d[4], 1'b1);
    `CHK_EQ(irq, msk[`WD_ST_EXPIRE]);
    rd(`WD_OFS_STATUS, d);
    `CHK_EQ(d[1:0], {rexp, 1'b1});
    wr(`WD_OFS_MASK, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK_EQ(irq, 1'b1);
    wr(`WD_OFS_STATUS, 32'h3);
    wr(`WD_OFS_REASON, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK_EQ(irq, 1'b0);
    rd(`WD_OFS_REASON, d);
    `CHK_EQ(d[`WD_REASON_WDOG], 1'b0);
    wr(`WD_OFS_CTRL, 32'h4);
    repeat (2) @(posedge aclk);
    `CHK_EQ({halt_irq, wdog_led}, 2'h0);
    rd(`WD_OFS_CTRL, d);
    `CHK_EQ(d[4:0], 5'h04);
    $display("test expiry ctrl %h mask %h done", ctl, msk);
  endtask

  initial begin
    word_t d;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK_EQ(halt_irq, 1'b0);
    rd(`WD_OFS_CTRL, d);
    `CHK_EQ(d[3:0], `WD_CTRL_RESET);
    rd(`WD_OFS_STATUS, d);
    `CHK_EQ(d[1:0], 2'h0);
    rd(8'h40, d);
    `CHK_EQ(d, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    wr(`WD_OFS_MASK, {16'h0, lfsr_next()});
    rd(`WD_OFS_MASK, d);
    `CHK_EQ(d[1:0], m_mask[1:0]);
    rd(`WD_OFS_CTRL, d);
    `CHK_EQ(d[2:0], m_ctrl[2:0]);
    $display("test reset and map done");
    // Regular servicing must keep a short timeout from ever expiring.
    wr(`WD_OFS_CTRL, 32'h1);
    wr(`WD_OFS_TIMEOUT, 32'h14);
    repeat (8) wr(`WD_OFS_CTRL, 32'h9);
    `CHK_EQ(halt_irq, 1'b0);
    rd(`WD_OFS_COUNT, d);
    `CHK_EQ(d > 0 && d <= 32'h14, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    m_ctrl = `WD_CTRL_RESET;
    `CHK_EQ({halt_irq, sys_reset, irq}, 3'h0);
    rd(`WD_OFS_CTRL, d);
    `CHK_EQ(d[4:0], {2'h0, m_ctrl[2:0]});
    $display("test service and mid-run reset done");
    expire_case(4'h7, 2'h1);
    expire_case(4'h1, 2'h1);
    expire_case(4'h5, 2'h0);
    summarize();
  end
endmodule
